// file: design/ea_calc.sv
// effective-address arithmetic for the indirect modes
// assumes the caller supplies register values already read
`default_nettype none
module ea_calc (
	ea_calc_if.calc c
);
	wire [15:0] inc_v = c.ptr_val + oag_pkg::MOD_STEP;
	wire [15:0] dec_v = c.ptr_val - oag_pkg::MOD_STEP;
	wire [15:0] idx_v = c.ptr_val + c.base_val;
	wire [15:0] lit_v = c.ptr_val + c.lit_val;

	// address, write-back value and memory use per mode
	always_comb begin
		c.ea      = c.ptr_val;
		c.ptr_new = c.ptr_val;
		c.ptr_upd = 1'b0;
		c.mem_use = 1'b1;
		unique case (c.mode)
			oag_pkg::AM_REG_DIRECT: c.mem_use = 1'b0;
			oag_pkg::AM_INDIRECT: c.ea = c.ptr_val;
			oag_pkg::AM_POST_INC: begin
				c.ptr_new = inc_v;
				c.ptr_upd = 1'b1;
			end
			oag_pkg::AM_POST_DEC: begin
				c.ptr_new = dec_v;
				c.ptr_upd = 1'b1;
			end
			oag_pkg::AM_PRE_INC: begin
				c.ea      = inc_v;
				c.ptr_new = inc_v;
				c.ptr_upd = 1'b1;
			end
			oag_pkg::AM_PRE_DEC: begin
				c.ea      = dec_v;
				c.ptr_new = dec_v;
				c.ptr_upd = 1'b1;
			end
			oag_pkg::AM_INDEXED: c.ea = idx_v;
			oag_pkg::AM_LIT_OFFSET: c.ea = lit_v;
		endcase
	end
endmodule
`default_nettype wire

// file: design/ea_calc_if.sv
// bundle between the generator and its effective-address unit
// assumes one clock; purely combinational signals
`default_nettype none
interface ea_calc_if;
	oag_pkg::addr_mode_t         mode;
	logic [oag_pkg::DATA_W-1:0]  ptr_val;
	logic [oag_pkg::DATA_W-1:0]  base_val;
	logic [oag_pkg::DATA_W-1:0]  lit_val;
	logic [oag_pkg::DATA_W-1:0]  ea;
	logic [oag_pkg::DATA_W-1:0]  ptr_new;
	logic                        ptr_upd;
	logic                        mem_use;
	modport calc (input mode, ptr_val, base_val, lit_val,
		output ea, ptr_new, ptr_upd, mem_use);
	modport user (output mode, ptr_val, base_val, lit_val,
		input ea, ptr_new, ptr_upd, mem_use);
endinterface
`default_nettype wire

// file: design/oag_pkg.sv
// operand addressing constants, shared by the generator and its helper
// assumes a 16-bit core with a 16-entry working register file
`default_nettype none
package oag_pkg;
	localparam int DATA_W     = 16;
	localparam int DEFAULT_WORKING_REG_CNT   = 16;
	localparam int NEAR_W     = 13;            // file-register field width
	localparam int NEAR_BYTES = 8192;          // near data space size
	localparam int LIT5_W     = 5;
	localparam int LIT10_W    = 10;
	localparam logic [3:0] WORKING_REG_ZERO = 4'h0;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] MOD_STEP   = 16'h0002;  // word-sized modify step

	// operand class from the decoder
	typedef enum logic [2:0] {
		CLS_FILE  = 3'h0,   // direct file-register
		CLS_MOVE  = 3'h1,   // move_op, full data space
		CLS_MUL   = 3'h2,   // multiply_op, register or pair result
		CLS_THREE = 3'h3,   // three-operand
		CLS_MAC   = 3'h4    // separate mode set, not decoded here
	} op_class_t;

	// addressing mode of the second source / result operand
	typedef enum logic [2:0] {
		AM_REG_DIRECT = 3'h0,
		AM_INDIRECT   = 3'h1,
		AM_POST_INC   = 3'h2,
		AM_POST_DEC   = 3'h3,
		AM_PRE_INC    = 3'h4,
		AM_PRE_DEC    = 3'h5,
		AM_INDEXED    = 3'h6,
		AM_LIT_OFFSET = 3'h7
	} addr_mode_t;

	// permitted mode mask bits
	localparam int MASK_W = 8;

	// states of the issue sequencer (one-hot)
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_ISSUE  = 3'b010,
		ST_WBACK  = 3'b100
	} seq_state_t;
endpackage
`default_nettype wire

// file: design/operand_address_generator.sv
// operand address generator: resolves operand locations and addresses
// assumes decoder fields arrive with a one-cycle valid strobe and the
// working register file answers reads combinationally
//
// How it works
// - file ops use 13-bit field, near space
// - default working reg is register zero
// - result to file reg or default reg
// - move op reaches the whole data space
// - first source is base reg, direct only
// - second source register, memory operand or 5-bit literal
// - result goes to register or memory
// - direct, indirect, post, pre, literal forms
// - each instruction allows only its mode subset
// - file direct uses the encoded address
// - register direct reads register, no memory
// - indirect uses pointer unchanged as address
// - post-modify: old pointer, then write back; only the source pointer when both operands modify different pointers
// - pre-modify: adjust, use, then write back; only the source pointer when both operands modify different pointers
// - indexed address is pointer plus base
// - literal offset address is pointer plus literal
// - multiply-accumulate modes handled elsewhere, rejected
`default_nettype none
module operand_address_generator #(
	parameter int DATA_W = oag_pkg::DATA_W
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// decoder request
	input  wire logic                 dec_valid,
	input  wire oag_pkg::op_class_t   dec_class,
	input  wire oag_pkg::addr_mode_t  dec_src_mode,
	input  wire oag_pkg::addr_mode_t  dec_dst_mode,
	input  wire logic [7:0]           dec_allowed,
	input  wire logic [15:0]          dec_file_addr,
	input  wire logic                 dec_to_default_working_reg,
	input  wire logic                 dec_src_is_lit,
	input  wire logic [9:0]           dec_literal,
	input  wire logic                 dec_lit10,
	input  wire logic [3:0]           dec_base_sel,
	input  wire logic [3:0]           dec_src_sel,
	input  wire logic [3:0]           dec_dst_sel,
	input  wire logic                 dec_mul_pair,
	// working register file read ports
	output logic [3:0]                rf_rd_a_sel,
	output logic [3:0]                rf_rd_b_sel,
	output logic [3:0]                rf_rd_c_sel,
	input  wire logic [DATA_W-1:0]    rf_rd_a,
	input  wire logic [DATA_W-1:0]    rf_rd_b,
	input  wire logic [DATA_W-1:0]    rf_rd_c,
	// pointer write-back port
	output logic                      ptr_wr_en,
	output logic [3:0]                ptr_wr_sel,
	output logic [DATA_W-1:0]         ptr_wr_data,
	// resolved operands
	output logic                      op_valid,
	output logic                      op_illegal,
	output logic [DATA_W-1:0]         op_base,
	output logic [DATA_W-1:0]         op_src_val,
	output logic                      op_src_mem,
	output logic [DATA_W-1:0]         op_src_addr,
	output logic                      op_dst_mem,
	output logic [DATA_W-1:0]         op_dst_addr,
	output logic [3:0]                op_dst_reg,
	output logic                      op_dst_pair
);
	// register file read selection is combinational from the request
	assign rf_rd_a_sel = dec_base_sel;
	assign rf_rd_b_sel = dec_src_sel;
	assign rf_rd_c_sel = dec_dst_sel;

	// bypass: a pointer whose write-back is on the port this cycle is forwarded to this request
	logic               wb_pend_reg;
	logic [3:0]         wb_sel_reg;
	logic [DATA_W-1:0]  wb_val_reg;
	logic               wb_pend_next;

	function automatic logic [DATA_W-1:0] fwd(input logic [3:0] sel,
		input logic [DATA_W-1:0] v);
		fwd = (wb_pend_reg && wb_sel_reg == sel) ? wb_val_reg : v;
	endfunction

	wire [DATA_W-1:0] base_v = fwd(dec_base_sel, rf_rd_a);
	wire [DATA_W-1:0] src_v  = fwd(dec_src_sel, rf_rd_b);
	wire [DATA_W-1:0] dst_v  = fwd(dec_dst_sel, rf_rd_c);

	// literal, 5 or 10 bits zero-extended; offset form uses signed 10
	wire [DATA_W-1:0] lit_zx = dec_lit10 ?
		{6'h00, dec_literal} : {11'h000, dec_literal[4:0]};
	wire [DATA_W-1:0] lit_sx = {{6{dec_literal[9]}}, dec_literal};

	// mode permission: decoder supplies each opcode's own subset
	wire src_ok = dec_src_is_lit || dec_allowed[dec_src_mode];
	wire dst_ok = dec_allowed[dec_dst_mode];
	wire is_three = dec_class == oag_pkg::CLS_THREE;
	wire is_mac   = dec_class == oag_pkg::CLS_MAC;
	wire lit_ok   = !dec_src_is_lit || !dec_lit10 || !is_three;
	wire dst_ok_both = !is_three || (dst_ok &&
		!(dec_src_mode inside {oag_pkg::AM_PRE_INC, oag_pkg::AM_PRE_DEC,
		oag_pkg::AM_POST_INC, oag_pkg::AM_POST_DEC} &&
		dec_dst_mode inside {oag_pkg::AM_PRE_INC, oag_pkg::AM_PRE_DEC,
		oag_pkg::AM_POST_INC, oag_pkg::AM_POST_DEC} &&
		dec_src_sel == dec_dst_sel && !dec_src_is_lit));
	wire illegal = is_mac || (is_three && !(src_ok && lit_ok)) ||
		!dst_ok_both;

	// source operand address unit
	ea_calc_if src_if ();
	assign src_if.mode     = dec_src_mode;
	assign src_if.ptr_val  = src_v;
	assign src_if.base_val = base_v;
	assign src_if.lit_val  = lit_sx;
	ea_calc u_src (
		.c (src_if)
	);

	// destination operand address unit
	ea_calc_if dst_if ();
	assign dst_if.mode     = dec_dst_mode;
	assign dst_if.ptr_val  = dst_v;
	assign dst_if.base_val = base_v;
	assign dst_if.lit_val  = lit_sx;
	ea_calc u_dst (
		.c (dst_if)
	);

	// direct file-register address: near field or full move address
	wire [DATA_W-1:0] near_addr =
		{3'h0, dec_file_addr[oag_pkg::NEAR_W-1:0]};
	wire [DATA_W-1:0] file_addr =
		(dec_class == oag_pkg::CLS_MOVE) ? dec_file_addr
		: near_addr;

	// next values of the resolved operand bundle
	logic               src_mem_n, dst_mem_n, pair_n, upd_n;
	logic [DATA_W-1:0]  src_addr_n, src_val_n, dst_addr_n, upd_val_n;
	logic [3:0]         dst_reg_n, upd_sel_n;

	always_comb begin
		src_mem_n  = 1'b0;
		src_addr_n = oag_pkg::RESET_WORD;
		src_val_n  = oag_pkg::RESET_WORD;
		dst_mem_n  = 1'b0;
		dst_addr_n = oag_pkg::RESET_WORD;
		dst_reg_n  = oag_pkg::WORKING_REG_ZERO;
		pair_n     = 1'b0;
		upd_n      = 1'b0;
		upd_sel_n  = dec_src_sel;
		upd_val_n  = src_if.ptr_new;
		unique case (dec_class)
			oag_pkg::CLS_FILE, oag_pkg::CLS_MOVE: begin
				src_mem_n  = 1'b1;
				src_addr_n = file_addr;
				dst_mem_n  = !dec_to_default_working_reg;
				dst_addr_n = file_addr;
				dst_reg_n  = oag_pkg::WORKING_REG_ZERO;
			end
			oag_pkg::CLS_MUL: begin
				src_mem_n  = 1'b1;
				src_addr_n = near_addr;
				dst_reg_n  = dec_dst_sel;
				pair_n     = dec_mul_pair;
			end
			oag_pkg::CLS_THREE: begin
				if (dec_src_is_lit) begin
					src_val_n = lit_zx;
				end else begin
					src_mem_n  = src_if.mem_use;
					src_addr_n = src_if.ea;
					src_val_n  = src_v;
					upd_n      = src_if.ptr_upd;
				end
				dst_mem_n  = dst_if.mem_use;
				dst_addr_n = dst_if.ea;
				dst_reg_n  = dec_dst_sel;
				if (!upd_n && dst_if.ptr_upd) begin
					upd_n     = 1'b1;
					upd_sel_n = dec_dst_sel;
					upd_val_n = dst_if.ptr_new;
				end
			end
			default: ;                                   // mac: refused
		endcase
	end

	// state machine: idle, issue a resolved operand, write pointer back
	oag_pkg::seq_state_t state_reg, state_next;
	wire take = dec_valid;
	assign wb_pend_next = take && !illegal && upd_n;

	always_comb begin
		state_next = oag_pkg::ST_IDLE;
		if (take) begin
			state_next = wb_pend_next ? oag_pkg::ST_WBACK
				: oag_pkg::ST_ISSUE;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) state_reg <= oag_pkg::ST_IDLE;
		else       state_reg <= state_next;
	end

	// forwarding copy of the pointer just written
	always_ff @(posedge clk) begin
		if (reset) begin
			wb_pend_reg <= 1'b0;
			wb_sel_reg  <= 4'h0;
			wb_val_reg  <= oag_pkg::RESET_WORD;
		end else begin
			wb_pend_reg <= wb_pend_next;
			wb_sel_reg  <= upd_sel_n;
			wb_val_reg  <= upd_val_n;
		end
	end

	// pointer write-back port, one pulse with the operand
	always_ff @(posedge clk) begin
		if (reset) begin
			ptr_wr_en   <= 1'b0;
			ptr_wr_sel  <= 4'h0;
			ptr_wr_data <= oag_pkg::RESET_WORD;
		end else begin
			ptr_wr_en   <= wb_pend_next;
			ptr_wr_sel  <= upd_sel_n;
			ptr_wr_data <= upd_val_n;
		end
	end

	// resolved operand bundle; illegal requests carry no operand
	always_ff @(posedge clk) begin
		if (reset) begin
			op_valid    <= 1'b0;
			op_illegal  <= 1'b0;
			op_base     <= oag_pkg::RESET_WORD;
			op_src_val  <= oag_pkg::RESET_WORD;
			op_src_mem  <= 1'b0;
			op_src_addr <= oag_pkg::RESET_WORD;
			op_dst_mem  <= 1'b0;
			op_dst_addr <= oag_pkg::RESET_WORD;
			op_dst_reg  <= 4'h0;
			op_dst_pair <= 1'b0;
		end else begin
			op_valid    <= take && !illegal;
			op_illegal  <= take && illegal;
			op_base     <= base_v;
			op_src_val  <= src_val_n;
			op_src_mem  <= take && !illegal && src_mem_n;
			op_src_addr <= src_addr_n;
			op_dst_mem  <= take && !illegal && dst_mem_n;
			op_dst_addr <= dst_addr_n;
			op_dst_reg  <= dst_reg_n;
			op_dst_pair <= pair_n;
		end
	end
endmodule
`default_nettype wire

// file: tb/oag_sva.sv
// port assertions for the operand address generator
// assumes one clock and a synchronous active-high reset
`default_nettype none
module oag_sva (
	// clock and reset
	input wire logic                clk,
	input wire logic                reset,
	// decoder request
	input wire logic                dec_valid,
	input wire oag_pkg::op_class_t  dec_class,
	input wire oag_pkg::addr_mode_t dec_src_mode,
	input wire oag_pkg::addr_mode_t dec_dst_mode,
	input wire logic [7:0]          dec_allowed,
	input wire logic [15:0]         dec_file_addr,
	input wire logic                dec_to_default_working_reg,
	input wire logic                dec_src_is_lit,
	// register file and results
	input wire logic [15:0]         rf_rd_a,
	input wire logic [15:0]         rf_rd_b,
	input wire logic                ptr_wr_en,
	input wire logic [15:0]         ptr_wr_data,
	input wire logic                op_valid,
	input wire logic                op_illegal,
	input wire logic [15:0]         op_src_val,
	input wire logic                op_src_mem,
	input wire logic [15:0]         op_src_addr,
	input wire logic [3:0]          op_dst_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// legal register source; no write-back in flight, so reads are fresh
	wire three_ok = dec_valid && dec_class == oag_pkg::CLS_THREE
		&& !dec_src_is_lit && !ptr_wr_en && dec_allowed[dec_src_mode]
		&& dec_allowed[0] && dec_dst_mode == oag_pkg::AM_REG_DIRECT;
	property p_answer;
		dec_valid |=> op_valid != op_illegal;
	endproperty
	a_answer: assert property (p_answer)
		else $error("request without single answer");
	property p_mac;
		dec_valid && dec_class == oag_pkg::CLS_MAC |=> op_illegal;
	endproperty
	a_mac: assert property (p_mac)
		else $error("mac class accepted");
	property p_near;
		dec_valid && dec_class == oag_pkg::CLS_FILE
			|=> op_src_addr == ($past(dec_file_addr) & 16'h1FFF);
	endproperty
	a_near: assert property (p_near)
		else $error("file address not near");
	property p_move;
		dec_valid && dec_class == oag_pkg::CLS_MOVE
			|=> op_src_addr == $past(dec_file_addr);
	endproperty
	a_move: assert property (p_move)
		else $error("move address cut");
	property p_default_working_reg;
		dec_valid && dec_class == oag_pkg::CLS_FILE && dec_to_default_working_reg
			|=> op_dst_reg == oag_pkg::WORKING_REG_ZERO;
	endproperty
	a_default_working_reg: assert property (p_default_working_reg)
		else $error("default register not zero");
	property p_direct;
		three_ok && dec_src_mode == oag_pkg::AM_REG_DIRECT
			|=> !op_src_mem && op_src_val == $past(rf_rd_b);
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct source wrong");
	property p_post;
		three_ok && dec_src_mode == oag_pkg::AM_POST_INC |=> ptr_wr_en
			&& op_src_addr == $past(rf_rd_b)
			&& ptr_wr_data == $past(rf_rd_b) + 16'h0002;
	endproperty
	a_post: assert property (p_post)
		else $error("post increment wrong");
	property p_index;
		three_ok && dec_src_mode == oag_pkg::AM_INDEXED
			|=> op_src_addr == $past(rf_rd_a) + $past(rf_rd_b);
	endproperty
	a_index: assert property (p_index)
		else $error("indexed address wrong");
endmodule
`default_nettype wire

// file: tb/rf_model.sv
// working register file model facing the generator
// assumes combinational reads and one pointer write per clock
`default_nettype none
module rf_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// read ports
	input  wire logic [3:0]  rf_rd_a_sel,
	input  wire logic [3:0]  rf_rd_b_sel,
	input  wire logic [3:0]  rf_rd_c_sel,
	output logic      [15:0] rf_rd_a,
	output logic      [15:0] rf_rd_b,
	output logic      [15:0] rf_rd_c,
	// pointer write-back
	input  wire logic        ptr_wr_en,
	input  wire logic [3:0]  ptr_wr_sel,
	input  wire logic [15:0] ptr_wr_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] regs [16];
	// same-cycle reads, as the generator expects
	assign rf_rd_a = regs[rf_rd_a_sel];
	assign rf_rd_b = regs[rf_rd_b_sel];
	assign rf_rd_c = regs[rf_rd_c_sel];
	// reset loads n*0x100 so every address is known in advance;
	// a write-back lands at the edge closing its ptr_wr_en cycle; a request taken at that edge still reads the old value
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= 16'(i) << 8;
			end
		end else if (ptr_wr_en) begin
			regs[ptr_wr_sel] <= ptr_wr_data;
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_operand_address_generator.sv
// self-checking bench for the operand address generator
// assumes rf_model as register file and oag_sva bound to uut
`default_nettype none
module tb_operand_address_generator;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk, reset, dec_valid, dec_to_default_working_reg, dec_src_is_lit;
	logic                dec_lit10, dec_mul_pair, ptr_wr_en, op_valid;
	logic                op_illegal, op_src_mem, op_dst_mem, op_dst_pair;
	oag_pkg::op_class_t  dec_class;
	oag_pkg::addr_mode_t dec_src_mode, dec_dst_mode;
	logic [7:0]          dec_allowed;
	logic [9:0]          dec_literal;
	logic [3:0]          dec_base_sel, dec_src_sel, dec_dst_sel, ptr_wr_sel;
	logic [3:0]          rf_rd_a_sel, rf_rd_b_sel, rf_rd_c_sel, op_dst_reg;
	logic [15:0]         dec_file_addr, rf_rd_a, rf_rd_b, rf_rd_c, op_base;
	logic [15:0]         ptr_wr_data, op_src_val, op_src_addr, op_dst_addr;
	int                  num_errors = 0;
	int                  checked = 0;
	operand_address_generator uut (.*);
	rf_model u_rf (.*);
	// 10 MHz core clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done;
		if (num_errors == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// valid stays high: requests go back to back, answer one edge later
	task automatic ask(input oag_pkg::op_class_t c,
		input oag_pkg::addr_mode_t m, input logic [3:0] s);
		dec_class = c;
		dec_src_mode = m;
		dec_src_sel = s;
		dec_valid = 1'b1;
		@(posedge clk);
		#1;
	endtask
	task automatic ea(input oag_pkg::addr_mode_t m, input logic [3:0] s,
		input logic [15:0] addr, input logic wb, input logic [15:0] nptr);
		ask(oag_pkg::CLS_THREE, m, s);
		chk("op_src_mem", 16'(op_src_mem), 16'h0001);
		chk("op_src_addr", op_src_addr, addr);
		chk("op_valid", 16'(op_valid), 16'h0001);
		chk("ptr_wr_en", 16'(ptr_wr_en), 16'(wb));
		if (wb) begin
			chk("ptr_wr_data", ptr_wr_data, nptr);
			chk("ptr_wr_sel", 16'(ptr_wr_sel), 16'(s));
		end
	endtask
	// file, move and multiply classes
	task automatic t_file;
		ask(oag_pkg::CLS_FILE, oag_pkg::AM_REG_DIRECT, 4'h0);
		chk("op_src_addr", op_src_addr, 16'h1FFF);
		dec_to_default_working_reg = 1'b1;
		ask(oag_pkg::CLS_FILE, oag_pkg::AM_REG_DIRECT, 4'h0);
		chk("op_dst_reg", 16'(op_dst_reg), 16'h0000);
		chk("op_dst_mem", 16'(op_dst_mem), 16'h0000);
		ask(oag_pkg::CLS_MOVE, oag_pkg::AM_REG_DIRECT, 4'h0);
		chk("op_src_addr", op_src_addr, 16'hFFFF);
		dec_mul_pair = 1'b1;
		dec_dst_sel = 4'h8;
		ask(oag_pkg::CLS_MUL, oag_pkg::AM_REG_DIRECT, 4'h0);
		chk("op_dst_reg", 16'(op_dst_reg), 16'h0008);
		chk("op_dst_pair", 16'(op_dst_pair), 16'h0001);
		dec_dst_sel = 4'h7;
	endtask
	// every source mode, pointers start at n*0x100
	task automatic t_modes;
		ask(oag_pkg::CLS_THREE, oag_pkg::AM_REG_DIRECT, 4'h6);
		chk("op_src_val", op_src_val, 16'h0600);
		chk("op_base", op_base, 16'h0100);
		ea(oag_pkg::AM_INDIRECT, 4'h5, 16'h0500, 1'b0, 16'h0000);
		ea(oag_pkg::AM_INDEXED, 4'h4, 16'h0500, 1'b0, 16'h0000);
		ea(oag_pkg::AM_LIT_OFFSET, 4'h4, 16'h03FE, 1'b0, 16'h0000);
		ea(oag_pkg::AM_POST_INC, 4'h2, 16'h0200, 1'b1, 16'h0202);
		ea(oag_pkg::AM_POST_INC, 4'h2, 16'h0202, 1'b1, 16'h0204);
		ea(oag_pkg::AM_POST_DEC, 4'h8, 16'h0800, 1'b1, 16'h07FE);
		ea(oag_pkg::AM_PRE_INC, 4'h9, 16'h0902, 1'b1, 16'h0902);
		ea(oag_pkg::AM_PRE_DEC, 4'h3, 16'h02FE, 1'b1, 16'h02FE);
		// register 2 now holds the value written back, no forwarding left
		ask(oag_pkg::CLS_THREE, oag_pkg::AM_REG_DIRECT, 4'h2);
		chk("op_src_val", op_src_val, 16'h0204);
	endtask
	// literals, memory result and refusals
	task automatic t_refuse;
		dec_src_is_lit = 1'b1;
		ask(oag_pkg::CLS_THREE, oag_pkg::AM_REG_DIRECT, 4'h0);
		chk("op_src_val", op_src_val, 16'h001E);
		dec_lit10 = 1'b1;
		ask(oag_pkg::CLS_THREE, oag_pkg::AM_REG_DIRECT, 4'h0);
		chk("op_illegal", 16'(op_illegal), 16'h0001);
		{dec_src_is_lit, dec_lit10} = 2'b00;
		dec_dst_mode = oag_pkg::AM_INDIRECT;
		dec_dst_sel = 4'hA;
		ask(oag_pkg::CLS_THREE, oag_pkg::AM_REG_DIRECT, 4'h6);
		chk("op_dst_addr", op_dst_addr, 16'h0A00);
		chk("op_dst_mem", 16'(op_dst_mem), 16'h0001);
		ask(oag_pkg::CLS_MAC, oag_pkg::AM_INDIRECT, 4'h5);
		chk("op_illegal", 16'(op_illegal), 16'h0001);
		// pre-decremented destination pointer, written back
		dec_dst_mode = oag_pkg::AM_PRE_DEC;
		ask(oag_pkg::CLS_THREE, oag_pkg::AM_REG_DIRECT, 4'h6);
		chk("op_dst_addr", op_dst_addr, 16'h09FE);
		chk("op_dst_mem", 16'(op_dst_mem), 16'h0001);
		chk("ptr_wr_en", 16'(ptr_wr_en), 16'h0001);
		chk("ptr_wr_sel", 16'(ptr_wr_sel), 16'h000A);
		chk("ptr_wr_data", ptr_wr_data, 16'h09FE);
		// both operands modifying one pointer is refused
		ask(oag_pkg::CLS_THREE, oag_pkg::AM_POST_INC, 4'hA);
		chk("op_illegal", 16'(op_illegal), 16'h0001);
		chk("ptr_wr_en", 16'(ptr_wr_en), 16'h0000);
		dec_dst_mode = oag_pkg::AM_REG_DIRECT;
		dec_allowed = 8'hFB;
		ask(oag_pkg::CLS_THREE, oag_pkg::AM_POST_INC, 4'h2);
		chk("op_illegal", 16'(op_illegal), 16'h0001);
		chk("ptr_wr_en", 16'(ptr_wr_en), 16'h0000);
	endtask
	// guard against a hung run
	initial begin
		#200000;
		num_errors++;
		test_done();
	end
	initial begin
		{dec_valid, dec_to_default_working_reg, dec_src_is_lit, dec_lit10, dec_mul_pair} = '0;
		dec_class = oag_pkg::CLS_FILE;
		dec_src_mode = oag_pkg::AM_REG_DIRECT;
		dec_dst_mode = oag_pkg::AM_REG_DIRECT;
		{dec_allowed, dec_literal, dec_file_addr} = {8'hFF, 10'h3FE, 16'hFFFF};
		{dec_base_sel, dec_src_sel, dec_dst_sel} = {4'h1, 4'h0, 4'h7};
		reset = 1'b1;
		repeat (6) @(posedge clk);
		#1;
		reset = 1'b0;
		t_file();
		t_modes();
		t_refuse();
		test_done();
	end
endmodule
bind operand_address_generator oag_sva u_sva (.clk, .reset, .dec_valid,
	.dec_class, .dec_src_mode, .dec_dst_mode, .dec_allowed, .dec_file_addr,
	.dec_to_default_working_reg, .dec_src_is_lit, .rf_rd_a, .rf_rd_b, .ptr_wr_en,
	.ptr_wr_data, .op_valid, .op_illegal, .op_src_val, .op_src_mem,
	.op_src_addr, .op_dst_reg);
`default_nettype wire
